// File: src/etp_pkg.sv
// Types shared by the timer core and its bench.
// Assumes etp_regs.svh is on the include path.
`default_nettype none
package etp_pkg;
   typedef enum logic [2:0] {
      ETP_MODE_NORMAL = 3'h0,
      ETP_MODE_PC_FF = 3'h1,
      ETP_MODE_CTC = 3'h2,
      ETP_MODE_FAST_FF = 3'h3,
      ETP_MODE_RSV4 = 3'h4,
      ETP_MODE_PC_CMPA = 3'h5,
      ETP_MODE_RSV6 = 3'h6,
      ETP_MODE_FAST_CMPA = 3'h7
   } etp_mode_t;

   typedef enum logic [2:0] {
      ETP_CS_STOP = 3'h0,
      ETP_CS_DIV1 = 3'h1,
      ETP_CS_DIV8 = 3'h2,
      ETP_CS_DIV64 = 3'h3,
      ETP_CS_DIV256 = 3'h4,
      ETP_CS_DIV1024 = 3'h5,
      ETP_CS_EXT_FALL = 3'h6,
      ETP_CS_EXT_RISE = 3'h7
   } etp_clk_sel_t;

   typedef struct packed {
      logic [1:0] com_a;
      logic [1:0] com_b;
      logic [1:0] rsv;
      logic [1:0] wgm_lo;
   } etp_ctrl_a_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } etp_bus_req_t;
endpackage : etp_pkg
`default_nettype wire

// File: src/etp_regs.svh
// Register map, field positions, reset values and counting limits of the
// timer core. Assumes an 8-bit register port with byte addresses.
`ifndef ETP_REGS_SVH
`define ETP_REGS_SVH

`define ETP_ADDR_W 8
`define ETP_DATA_W 8

`define ETP_OFF_CTRL_A 8'h44
`define ETP_OFF_CTRL_B 8'h45
`define ETP_OFF_COUNT 8'h46
`define ETP_OFF_CMP_A 8'h47
`define ETP_OFF_CMP_B 8'h48
`define ETP_OFF_FLAGS 8'h35
`define ETP_OFF_IRQ_EN 8'h6E

`define ETP_RST_BYTE 8'h00
`define ETP_RST_EVT 3'h0
`define ETP_RST_CS 3'h0
`define ETP_RST_COM 2'h0
`define ETP_RST_WGM_LO 2'h0

`define ETP_BIT_FORCE_A 7
`define ETP_BIT_FORCE_B 6
`define ETP_BIT_WGM_HI 3
`define ETP_BIT_EVT_CMP_B 2
`define ETP_BIT_EVT_CMP_A 1
`define ETP_BIT_EVT_OVF 0

`define ETP_MAX 8'hFF
`define ETP_BOTTOM 8'h00
`define ETP_PRE_W 10
`define ETP_PRE_DIV8 3
`define ETP_PRE_DIV64 6
`define ETP_PRE_DIV256 8
`define ETP_PRE_DIV1024 10

`endif

// File: src/etp_timer_core.sv
// Eight-bit timer/counter with two compare channels and PWM modes.
// Assumes a single synchronous register master and an asynchronous count pin.
//
// Operation
// [R1] Waveform mode is high bit of control B over two low bits of A.
// [R2] Normal tops at 0xFF, clear-on-compare tops at compare A; both immediate.
// [R3] Fast PWM tops at 0xFF or compare A; compare loads at bottom.
// [R4] Phase-correct tops at 0xFF or compare A; loads at top, overflow at bottom.
// [R5] Force bits act on outputs through output mode in non-PWM modes only.
// [R6] Software writes zero to force bits while a PWM mode runs.
// [R7] Forced compare sets no flag, no interrupt, and clears no counter.
// [R8] Force bits always read back zero.
// [R9] Reserved control and interrupt-enable bits read zero.
// [R10] Clock source: stop, divide 1, 8, 64, 256, 1024.
// [R11] Source codes 6 and 7 count falling or rising count-pin edges.
// [R12] The count pin counts even while it is used as an output.
// [R13] Count register is directly readable and writable.
// [R14] A count write blocks the compare match on the next timer tick.
// [R15] Values jumped over by a count write need not match.
// [R16] Both compare values meet the count every tick, setting flags.
// [R17] Enable, global enable and flag together request an interrupt.
// [R18] Output mode 00 off, 01 toggle, 10 clear, 11 set on match.
// [R19] Flags clear on vector acknowledge or on writing one.
`include "etp_regs.svh"
`default_nettype none
module etp_timer_core (
   // Clock and reset.
   input wire logic SYS_CLK_I,
   input wire logic NRST_I,
   // Register port.
   input wire etp_pkg::etp_bus_req_t BUS_REQ_I,
   output logic [7:0] RD_DATA_O,
   // Interrupt side.
   input wire logic GLOBAL_IRQ_EN_I,
   input wire logic [2:0] IRQ_ACK_I,
   output logic IRQ_O,
   // Pins.
   input wire logic EXT_COUNT_PIN_I,
   output logic WAVE_OUTPUT_A_O,
   output logic WAVE_OUTPUT_A_OE_O,
   output logic WAVE_OUTPUT_B_O,
   output logic WAVE_OUTPUT_B_OE_O
);
   import etp_pkg::*;

   localparam logic [1:0] GRP_PLAIN = 2'h0;
   localparam logic [1:0] GRP_FAST = 2'h1;
   localparam logic [1:0] GRP_PC = 2'h2;

   etp_ctrl_a_t ctrl_a_q;
   logic wgm_hi_q;
   etp_clk_sel_t cs_q;
   logic [7:0] cnt_q, cnt_d;
   logic dir_q, dir_d;
   logic [7:0] cmp_a_q, cmp_b_q, cmp_a_act_q, cmp_b_act_q;
   logic [2:0] ien_q, flag_q, flag_d;
   logic block_q;
   logic [`ETP_PRE_W-1:0] pre_q;
   logic pin_s1_q, pin_s2_q, pin_s3_q;
   logic wave_a_q, wave_b_q, oe_a_q, oe_b_q;
   logic [7:0] rd_data_q;
   logic irq_q;

   etp_mode_t mode;
   logic is_fast, is_pc, is_pwm;
   logic [1:0] grp;
   logic [7:0] top, cmp_a_eff, cmp_b_eff, rd_mux;
   logic tick, at_top, at_bot, ev_tick, wrap;
   logic ovf_evt, ev_a, ev_b, upd;
   logic wr_cnt, wr_b, force_a, force_b;
   logic [2:0] clr;

   // True when every low bit of the prescaler is one.
   function automatic logic pre_done(input logic [`ETP_PRE_W-1:0] p,
                                     input int n);
      logic r;
      r = 1'b1;
      for (int i = 0; i < `ETP_PRE_W; i++) begin
         if (i < n) begin
            r = r & p[i];
         end
      end
      return r;
   endfunction

   // Next level of a wave output for one timer event or forced compare.
   function automatic logic wave_next(input logic [1:0] g,
                                      input logic [1:0] com,
                                      input logic tog_ok,
                                      input logic cur,
                                      input logic match,
                                      input logic frc,
                                      input logic wrp,
                                      input logic cmp_is_top,
                                      input logic down);
      logic r;
      r = cur;
      if (g == GRP_PLAIN) begin
         if (match || frc) begin
            case (com)
               2'h1: r = ~cur;
               2'h2: r = 1'b0;
               2'h3: r = 1'b1;
               default: r = cur;
            endcase
         end
      end else if (com == 2'h1) begin
         if (match && tog_ok) begin
            r = ~cur;
         end
      end else if (com[1]) begin
         if (g == GRP_FAST) begin
            if (wrp) begin
               r = ~com[0];
            end else if (match && !cmp_is_top) begin
               r = com[0];
            end
         end else if (match) begin
            r = down ? ~com[0] : com[0];
         end
      end
      return r;
   endfunction

   assign mode = etp_mode_t'({wgm_hi_q, ctrl_a_q.wgm_lo}); // [R1]
   assign is_fast = (mode == ETP_MODE_FAST_FF) ||
                    (mode == ETP_MODE_FAST_CMPA);
   assign is_pc = (mode == ETP_MODE_PC_FF) || (mode == ETP_MODE_PC_CMPA);
   assign is_pwm = is_fast || is_pc;
   assign grp = is_pc ? GRP_PC : (is_fast ? GRP_FAST : GRP_PLAIN);

   // Non-PWM modes see compare writes at once; PWM modes use the copy.
   assign cmp_a_eff = is_pwm ? cmp_a_act_q : cmp_a_q; // [R2]
   assign cmp_b_eff = is_pwm ? cmp_b_act_q : cmp_b_q; // [R2]
   assign top = ((mode == ETP_MODE_CTC) || (mode == ETP_MODE_PC_CMPA) ||
                 (mode == ETP_MODE_FAST_CMPA)) ? cmp_a_eff : `ETP_MAX;
   assign at_top = (cnt_q == top);
   assign at_bot = (cnt_q == `ETP_BOTTOM);

   assign wr_cnt = BUS_REQ_I.wr && (BUS_REQ_I.addr == `ETP_OFF_COUNT);
   assign wr_b = BUS_REQ_I.wr && (BUS_REQ_I.addr == `ETP_OFF_CTRL_B);
   assign force_a = wr_b && BUS_REQ_I.wdata[`ETP_BIT_FORCE_A] && !is_pwm; // [R5]
   assign force_b = wr_b && BUS_REQ_I.wdata[`ETP_BIT_FORCE_B] && !is_pwm; // [R5]

   // Timer tick selection; the count pin is read from its second stage.
   always_comb begin
      case (cs_q) // [R10]
         ETP_CS_STOP: tick = 1'b0;
         ETP_CS_DIV1: tick = 1'b1;
         ETP_CS_DIV8: tick = pre_done(pre_q, `ETP_PRE_DIV8);
         ETP_CS_DIV64: tick = pre_done(pre_q, `ETP_PRE_DIV64);
         ETP_CS_DIV256: tick = pre_done(pre_q, `ETP_PRE_DIV256);
         ETP_CS_DIV1024: tick = pre_done(pre_q, `ETP_PRE_DIV1024);
         ETP_CS_EXT_FALL: tick = pin_s3_q && !pin_s2_q; // [R11] [R12]
         default: tick = !pin_s3_q && pin_s2_q; // [R11] [R12]
      endcase
   end

   // A count write in the same cycle overrides any counting event.
   assign ev_tick = tick && !wr_cnt; // [R15]
   assign wrap = ev_tick && !is_pc && at_top;
   assign ev_a = ev_tick && !block_q && (cnt_q == cmp_a_eff); // [R14] [R16]
   assign ev_b = ev_tick && !block_q && (cnt_q == cmp_b_eff); // [R14] [R16]
   assign upd = ev_tick && at_top && (is_fast || (is_pc && !dir_q)); // [R3] [R4]

   always_comb begin
      if (is_pc) begin
         ovf_evt = ev_tick && dir_q && at_bot; // [R4]
      end else if (mode == ETP_MODE_FAST_CMPA) begin
         ovf_evt = ev_tick && at_top; // [R3]
      end else begin
         ovf_evt = ev_tick && (cnt_q == `ETP_MAX); // [R2] [R3]
      end
   end

   // Next count and direction.
   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      if (wr_cnt) begin
         cnt_d = BUS_REQ_I.wdata; // [R13]
      end else if (tick) begin
         if (is_pc) begin // [R4]
            if (!dir_q && at_top) begin
               dir_d = 1'b1;
               cnt_d = cnt_q - 8'h01;
            end else if (dir_q && at_bot) begin
               dir_d = 1'b0;
               cnt_d = cnt_q + 8'h01;
            end else begin
               cnt_d = dir_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
            end
         end else if (at_top) begin
            cnt_d = `ETP_BOTTOM; // [R2] [R3]
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cnt_q <= `ETP_RST_BYTE;
         dir_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         block_q <= 1'b0;
      end else if (wr_cnt) begin
         block_q <= 1'b1; // [R14]
      end else if (tick) begin
         block_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pre_q <= '0;
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pre_q <= pre_q + `ETP_PRE_W'(1);
         pin_s1_q <= EXT_COUNT_PIN_I;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // Control and compare registers written by software.
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ctrl_a_q <= etp_ctrl_a_t'(`ETP_RST_BYTE);
         wgm_hi_q <= 1'b0;
         cs_q <= etp_clk_sel_t'(`ETP_RST_CS);
         cmp_a_q <= `ETP_RST_BYTE;
         cmp_b_q <= `ETP_RST_BYTE;
         ien_q <= `ETP_RST_EVT;
      end else if (BUS_REQ_I.wr) begin
         if (BUS_REQ_I.addr == `ETP_OFF_CTRL_A) begin
            ctrl_a_q <= BUS_REQ_I.wdata;
            ctrl_a_q.rsv <= 2'h0; // [R9]
         end else if (BUS_REQ_I.addr == `ETP_OFF_CTRL_B) begin
            wgm_hi_q <= BUS_REQ_I.wdata[`ETP_BIT_WGM_HI];
            cs_q <= etp_clk_sel_t'(BUS_REQ_I.wdata[2:0]);
         end else if (BUS_REQ_I.addr == `ETP_OFF_CMP_A) begin
            cmp_a_q <= BUS_REQ_I.wdata;
         end else if (BUS_REQ_I.addr == `ETP_OFF_CMP_B) begin
            cmp_b_q <= BUS_REQ_I.wdata;
         end else if (BUS_REQ_I.addr == `ETP_OFF_IRQ_EN) begin
            ien_q <= BUS_REQ_I.wdata[2:0];
         end
      end
   end

   // Active compare copies follow at once outside PWM, else at the edge.
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cmp_a_act_q <= `ETP_RST_BYTE;
         cmp_b_act_q <= `ETP_RST_BYTE;
      end else if (!is_pwm || upd) begin // [R3] [R4]
         cmp_a_act_q <= cmp_a_q;
         cmp_b_act_q <= cmp_b_q;
      end
   end

   // Flags: a new event wins over a clear in the same cycle.
   assign clr = IRQ_ACK_I | ((BUS_REQ_I.wr &&
                 BUS_REQ_I.addr == `ETP_OFF_FLAGS) ?
                 BUS_REQ_I.wdata[2:0] : `ETP_RST_EVT); // [R19]
   assign flag_d = (flag_q & ~clr) | {ev_b, ev_a, ovf_evt}; // [R7] [R16]

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         flag_q <= `ETP_RST_EVT;
         irq_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         irq_q <= GLOBAL_IRQ_EN_I && |(flag_d & ien_q); // [R17]
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
         oe_a_q <= 1'b0;
         oe_b_q <= 1'b0;
      end else begin
         wave_a_q <= wave_next(grp, ctrl_a_q.com_a, wgm_hi_q, wave_a_q,
                               ev_a, force_a, wrap, cmp_a_eff == top,
                               dir_q); // [R5] [R18]
         wave_b_q <= wave_next(grp, ctrl_a_q.com_b, 1'b0, wave_b_q,
                               ev_b, force_b, wrap, cmp_b_eff == top,
                               dir_q); // [R5] [R18]
         oe_a_q <= (ctrl_a_q.com_a != `ETP_RST_COM); // [R18]
         oe_b_q <= (ctrl_a_q.com_b != `ETP_RST_COM); // [R18]
      end
   end

   // Read decode; unmapped addresses return zero.
   always_comb begin
      if (BUS_REQ_I.addr == `ETP_OFF_CTRL_A) begin
         rd_mux = {ctrl_a_q.com_a, ctrl_a_q.com_b, 2'h0,
                   ctrl_a_q.wgm_lo}; // [R9]
      end else if (BUS_REQ_I.addr == `ETP_OFF_CTRL_B) begin
         rd_mux = {4'h0, wgm_hi_q, cs_q}; // [R8] [R9]
      end else if (BUS_REQ_I.addr == `ETP_OFF_COUNT) begin
         rd_mux = cnt_q; // [R13]
      end else if (BUS_REQ_I.addr == `ETP_OFF_CMP_A) begin
         rd_mux = cmp_a_q;
      end else if (BUS_REQ_I.addr == `ETP_OFF_CMP_B) begin
         rd_mux = cmp_b_q;
      end else if (BUS_REQ_I.addr == `ETP_OFF_IRQ_EN) begin
         rd_mux = {5'h00, ien_q}; // [R9]
      end else if (BUS_REQ_I.addr == `ETP_OFF_FLAGS) begin
         rd_mux = {5'h00, flag_q};
      end else begin
         rd_mux = `ETP_RST_BYTE;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rd_data_q <= `ETP_RST_BYTE;
      end else begin
         rd_data_q <= BUS_REQ_I.rd ? rd_mux : `ETP_RST_BYTE;
      end
   end

   assign RD_DATA_O = rd_data_q;
   assign IRQ_O = irq_q;
   assign WAVE_OUTPUT_A_O = wave_a_q;
   assign WAVE_OUTPUT_B_O = wave_b_q;
   assign WAVE_OUTPUT_A_OE_O = oe_a_q;
   assign WAVE_OUTPUT_B_OE_O = oe_b_q;

   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!NRST_I);

   a_force_read_zero: assert property ( // [R8]
      BUS_REQ_I.rd && BUS_REQ_I.addr == `ETP_OFF_CTRL_B
      |=> RD_DATA_O[7:4] == 4'h0)
      else $error("force or reserved bits read nonzero");
   a_rsv_read_zero: assert property ( // [R9]
      BUS_REQ_I.rd && BUS_REQ_I.addr == `ETP_OFF_IRQ_EN
      |=> RD_DATA_O[7:3] == 5'h00 && RD_DATA_O[2:0] == $past(ien_q))
      else $error("enable register readback wrong");
   a_force_no_flag: assert property ( // [R7]
      force_a && !ev_a && !flag_q[`ETP_BIT_EVT_CMP_A]
      |=> !flag_q[`ETP_BIT_EVT_CMP_A] && cnt_q == $past(cnt_d))
      else $error("forced compare set a flag");
   a_count_write_load: assert property ( // [R13]
      wr_cnt |=> cnt_q == $past(BUS_REQ_I.wdata) ##1 !ev_a || !block_q)
      else $error("count write not loaded");
   a_match_blocked: assert property ( // [R14]
      wr_cnt ##1 (tick && cnt_q == cmp_a_eff && !wr_cnt)
      |=> !$rose(flag_q[`ETP_BIT_EVT_CMP_A]))
      else $error("match not blocked after count write");
   a_cmp_flag_set: assert property ( // [R16]
      ev_b |=> flag_q[`ETP_BIT_EVT_CMP_B])
      else $error("compare B flag missing");
   a_ctc_wrap: assert property ( // [R2]
      mode == ETP_MODE_CTC && tick && at_top && !wr_cnt
      |=> cnt_q == `ETP_BOTTOM)
      else $error("clear-on-compare did not clear");
   a_stop_hold: assert property ( // [R10]
      cs_q == ETP_CS_STOP && !wr_cnt |=> $stable(cnt_q))
      else $error("stopped counter moved");
   a_pc_ovf_bottom: assert property ( // [R4]
      is_pc && tick && !wr_cnt && dir_q && at_bot
      |=> flag_q[`ETP_BIT_EVT_OVF] && !dir_q)
      else $error("phase-correct overflow missed");
   a_irq_level: assert property ( // [R17]
      IRQ_O |-> $past(GLOBAL_IRQ_EN_I) && |($past(flag_d & ien_q)))
      else $error("interrupt without cause");
   a_ack_clears: assert property ( // [R19]
      IRQ_ACK_I[`ETP_BIT_EVT_OVF] && !ovf_evt
      |=> !flag_q[`ETP_BIT_EVT_OVF])
      else $error("acknowledge did not clear overflow flag");
endmodule // etp_timer_core
`default_nettype wire

// File: verification/test_etp_timer_core.sv
// Self-checking bench for the eight-bit timer core: registers, counting,
// compare flags, interrupt, forced compare and external count pin.
// Assumes etp_regs.svh is on the include path and etp_pkg is compiled first.
`include "etp_regs.svh"
`default_nettype none
module test_etp_timer_core import etp_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] a_ca = `ETP_OFF_CTRL_A;
   localparam logic [7:0] a_cb = `ETP_OFF_CTRL_B;
   localparam logic [7:0] a_cnt = `ETP_OFF_COUNT;
   localparam logic [7:0] a_ocra = `ETP_OFF_CMP_A;
   localparam logic [7:0] a_ocrb = `ETP_OFF_CMP_B;
   localparam logic [7:0] a_flg = `ETP_OFF_FLAGS;
   localparam logic [7:0] a_ien = `ETP_OFF_IRQ_EN;
   logic sys_clk, nrst, gie, pin, irq, wa, wa_oe, wb, wb_oe;
   logic [2:0] ack;
   logic [7:0] rdata;
   etp_bus_req_t req;
   int n_mismatch = 0;
   int n_tests = 0;

   etp_timer_core dut (
      .SYS_CLK_I(sys_clk), .NRST_I(nrst), .BUS_REQ_I(req), .RD_DATA_O(rdata),
      .GLOBAL_IRQ_EN_I(gie), .IRQ_ACK_I(ack), .IRQ_O(irq),
      .EXT_COUNT_PIN_I(pin), .WAVE_OUTPUT_A_O(wa), .WAVE_OUTPUT_A_OE_O(wa_oe),
      .WAVE_OUTPUT_B_O(wb), .WAVE_OUTPUT_B_OE_O(wb_oe)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi,
                          input logic [7:0] g);
      n_tests++;
      if ($isunknown(g) || int'(g) < lo || int'(g) > hi) begin
         n_mismatch++;
         $display("mismatch %s expected %0d..%0d seen %h", nm, lo, hi, g);
      end
   endtask

   // The strobe is dropped at the edge that takes it, so each access is whole.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      rd(a, d);
      chk(nm, e, d);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic t_regs;
      logic [7:0] addrs [7] = '{a_ca, a_cb, a_cnt, a_ocra, a_ocrb, a_flg, a_ien};
      foreach (addrs[i]) rchk(addrs[i], 8'h00, "reset value");
      wr(a_ca, 8'hFF);
      rchk(a_ca, 8'hF3, "control a");
      wr(a_ca, 8'h00);
      wr(a_cb, 8'hF0);
      rchk(a_cb, 8'h00, "control b");
      wr(a_ien, 8'hFF);
      rchk(a_ien, 8'h07, "irq enable");
      wr(a_ien, 8'h00);
      wr(8'h50, 8'hFF);
      rchk(8'h50, 8'h00, "unmapped");
      wr(a_cnt, 8'hA5);
      rchk(a_cnt, 8'hA5, "count");
      wr(a_ocra, 8'h5A);
      rchk(a_ocra, 8'h5A, "compare a");
      wr(a_ocrb, 8'hC3);
      rchk(a_ocrb, 8'hC3, "compare b");
      $display("test registers done");
   endtask

   task automatic t_irq;
      wr(a_cnt, 8'hF0);
      wr(a_ocra, 8'hF8);
      wr(a_ocrb, 8'hF4);
      wr(a_flg, 8'h07);
      wr(a_ien, 8'h07);
      gie <= 1'b1;
      wr(a_cb, 8'h01);
      wait_n(30);
      wr(a_cb, 8'h00);
      rchk(a_flg, 8'h07, "flags");
      chk("irq", 8'h01, {7'h0, irq});
      wr(a_ien, 8'h00);
      wait_n(2);
      chk("irq masked", 8'h00, {7'h0, irq});
      wr(a_ien, 8'h01);
      wait_n(2);
      chk("irq ovf", 8'h01, {7'h0, irq});
      @(posedge sys_clk);
      ack <= 3'h1;
      @(posedge sys_clk);
      ack <= 3'h0;
      wait_n(2);
      chk("irq after ack", 8'h00, {7'h0, irq});
      rchk(a_flg, 8'h06, "flags after ack");
      wr(a_ien, 8'h06);
      gie <= 1'b0;
      wait_n(2);
      chk("irq no global", 8'h00, {7'h0, irq});
      gie <= 1'b1;
      wait_n(2);
      chk("irq global", 8'h01, {7'h0, irq});
      wr(a_flg, 8'h06);
      wait_n(2);
      chk("irq cleared", 8'h00, {7'h0, irq});
      rchk(a_flg, 8'h00, "flags cleared");
      $display("test interrupt done");
   endtask

   task automatic t_count_write;
      wr(a_ocra, 8'h20);
      wr(a_ocrb, 8'h21);
      wr(a_cnt, 8'h20);
      wr(a_cb, 8'h01);
      wait_n(4);
      wr(a_cb, 8'h00);
      rchk(a_flg, 8'h04, "match after count write");
      wr(a_flg, 8'h07);
      $display("test count write done");
   endtask

   task automatic t_prescale;
      int divs [4] = '{8, 64, 256, 1024};
      logic [7:0] d;
      d = 8'h00;
      for (int i = 0; i < 4; i++) begin
         wr(a_cnt, 8'h00);
         wr(a_cb, 8'(i + 2));
         repeat (20 * divs[i]) @(posedge sys_clk);
         wr(a_cb, 8'h00);
         rd(a_cnt, d);
         chk_rng("divided count", 19, 21, d);
      end
      wait_n(20);
      rchk(a_cnt, d, "stopped count");
      wr(a_flg, 8'h07);
      $display("test prescaler done");
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge sys_clk);
         pin <= 1'b1;
         repeat (4) @(posedge sys_clk);
         pin <= 1'b0;
      end
      wait_n(8);
   endtask

   task automatic t_ext;
      wr(a_ca, 8'h40);
      wr(a_cnt, 8'h00);
      wr(a_cb, 8'h07);
      pulses(5);
      rchk(a_cnt, 8'h05, "rising edge count");
      wr(a_cb, 8'h06);
      pulses(3);
      rchk(a_cnt, 8'h08, "falling edge count");
      wr(a_cb, 8'h00);
      wr(a_ca, 8'h00);
      wr(a_flg, 8'h07);
      $display("test external pin done");
   endtask

   task automatic t_force;
      logic [1:0] com [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
      logic exp_o [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      for (int ch = 0; ch < 2; ch++) begin
         for (int i = 0; i < 4; i++) begin
            wr(a_ca, ch == 0 ? {com[i], 6'h00} : {2'h0, com[i], 4'h0});
            wr(a_cb, ch == 0 ? 8'h80 : 8'h40);
            wait_n(2);
            chk("wave out", {7'h0, exp_o[i]}, {7'h0, ch == 0 ? wa : wb});
            chk("wave oe", 8'h01, {7'h0, ch == 0 ? wa_oe : wb_oe});
         end
      end
      rchk(a_flg, 8'h00, "flags after force");
      wr(a_ca, 8'h00);
      wait_n(2);
      chk("oe off", 8'h00, {6'h0, wa_oe, wb_oe});
      wr(a_ca, 8'hC2);
      wr(a_ocra, 8'h33);
      wr(a_cnt, 8'h33);
      wr(a_cb, 8'h80);
      wait_n(2);
      chk("forced set", 8'h01, {7'h0, wa});
      rchk(a_cnt, 8'h33, "count after force");
      rchk(a_flg, 8'h00, "flags after force");
      $display("test force done");
   endtask

   task automatic t_modes;
      logic [7:0] d;
      wr(a_ca, 8'h42);
      wr(a_ocra, 8'h05);
      wr(a_cnt, 8'h00);
      wr(a_cb, 8'h01);
      wait_n(40);
      wr(a_cb, 8'h00);
      rd(a_cnt, d);
      chk_rng("clear on compare count", 0, 5, d);
      rchk(a_flg, 8'h02, "clear on compare flags");
      wr(a_flg, 8'h07);
      wr(a_ocra, 8'h10);
      wr(a_ca, 8'h03);
      wr(a_cb, 8'h09);
      wait_n(400);
      wr(a_flg, 8'h07);
      wait_n(40);
      wr(a_cb, 8'h08);
      rd(a_cnt, d);
      chk_rng("fast top count", 0, 16, d);
      rd(a_flg, d);
      chk("fast overflow at top", 8'h01, {7'h0, d[0]});
      wr(a_ocra, 8'h08);
      wr(a_ca, 8'h01);
      wr(a_cb, 8'h09);
      wait_n(600);
      wr(a_flg, 8'h07);
      wait_n(40);
      wr(a_cb, 8'h08);
      rd(a_cnt, d);
      chk_rng("phase top count", 0, 8, d);
      rd(a_flg, d);
      chk("phase overflow", 8'h01, {7'h0, d[0]});
      $display("test modes done");
   endtask

   initial begin
      nrst = 1'b0;
      gie = 1'b0;
      pin = 1'b0;
      ack = 3'h0;
      req = '0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      t_regs();
      t_irq();
      t_count_write();
      t_prescale();
      t_ext();
      t_force();
      t_modes();
      end_sim();
   end

   // The tests take about 28600 cycles; more than twice that means a hang.
   initial begin
      repeat (64000) @(posedge sys_clk);
      n_mismatch++;
      $display("timeout waiting for tests");
      end_sim();
   end
endmodule // test_etp_timer_core
`default_nettype wire
